// ### design/sfdma_top.sv
// Flash image DMA: parameter registers over AXI4-Lite and the copy engine
// Functional notes
// (RL1) Source address is 32 bits over four byte registers, low byte lowest.
// (RL2) Source address is the flash byte address of the first read, unscaled.
// (RL3) Colour/window config bit 2 chooses block (0) or linear (1) mode.
// (RL4) Block mode: X corner is 13 bits, low byte plus bits 4:0 of high.
// (RL5) Linear mode: X bytes give destination address bits 15:2.
// (RL6) Block mode: Y corner is 13 bits, low byte plus bits 4:0 of high.
// (RL7) Linear mode: Y bytes give destination address bits 31:16.
// (RL8) Block mode: width bytes give 16-bit block width.
// (RL9) Linear mode: width bytes give transfer count bits 15:0.
// (RL10) Block mode: height bytes give 16-bit block height.
// (RL11) Linear mode: height bytes give transfer count bits 31:16.
// (RL12) Source picture width is 13 bits, low byte plus bits 4:0 of high.
// (RL13) The two reserved bytes between Y and width read zero, ignore writes.
// (RL14) The SPI clock mode must be 0 or 3 while the flash DMA runs.
// (RL15) Block mode: rows of width pixels, flash row start steps by picture width.
// (RL16) Linear mode: count bytes copied to consecutive addresses from destination.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module sfdma_top
  import sfdma_pkg::*;
#(
  parameter int FIFO_W = 8,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output sfdma_req_t       fl_req,
  output logic             fl_req_valid,
  input  wire logic        fl_req_ready,
  input  wire logic [7:0]  fl_data,
  input  wire logic        fl_data_valid,
  output logic             fl_data_ready,
  output sfdma_wr_t        mem_wr,
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output logic [1:0]       spi_mode,
  output logic             busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Register window BCh..CBh as an indexed byte store
  logic [7:0]   win_q [16];
  logic         lin_cfg_q;
  logic [1:0]   mode_q;
  logic         done_q, err_q;
  logic         aw_have_q, w_have_q;
  logic [7:0]   aw_idx_q;
  logic [7:0]   wbyte_q;
  logic         wstrb0_q;
  sfdma_state_t state_q;
  logic         lin_q;
  logic [31:0]  row_addr_q, left_q, len_q, addr_q;
  logic [15:0]  rows_left_q;
  logic [12:0]  swid_q, dx_q, x_q, y_q;
  logic [7:0]   ff_data;
  logic         ff_valid, ff_pop;

  function automatic logic [3:0] slot(input logic [7:0] idx);
    slot = 4'(idx - IDX_SRC0);
  endfunction
  function automatic logic in_win(input logic [7:0] idx);
    in_win = (idx >= IDX_SRC0) && (idx <= IDX_SWID_HI);
  endfunction
  function automatic logic is_rsvd(input logic [7:0] idx);
    is_rsvd = (idx == IDX_RSV0) || (idx == IDX_RSV1);
  endfunction
  function automatic logic mapped(input logic [7:0] idx);
    mapped = in_win(idx) || (idx == IDX_COLOR) || (idx == IDX_CTRL) || (idx == IDX_STAT);
  endfunction
  function automatic logic [7:0] wb(input logic [7:0] idx);
    wb = win_q[slot(idx)];
  endfunction

  // Assembled register fields, rebuilt whenever a stored byte changes
  logic [31:0] src_f, cnt_f, lin_dst_f;
  logic [12:0] dx_f, dy_f, swid_f;
  logic [15:0] wid_f, hgt_f;
  always_comb begin
    src_f     = {wb(IDX_SRC3), wb(IDX_SRC2), wb(IDX_SRC1), wb(IDX_SRC0)}; // RL1
    dx_f      = {win_q[slot(IDX_DX_HI)][4:0], wb(IDX_DX_LO)}; // RL4
    dy_f      = {win_q[slot(IDX_DY_HI)][4:0], wb(IDX_DY_LO)}; // RL6
    lin_dst_f = {wb(IDX_DY_HI), wb(IDX_DY_LO), wb(IDX_DX_HI), // RL5 RL7
                 win_q[slot(IDX_DX_LO)][7:2], 2'b00};
    wid_f     = {wb(IDX_WID_HI), wb(IDX_WID_LO)}; // RL8
    hgt_f     = {wb(IDX_HGT_HI), wb(IDX_HGT_LO)}; // RL10
    cnt_f     = {hgt_f, wid_f}; // RL9 RL11
    swid_f    = {win_q[slot(IDX_SWID_HI)][4:0], wb(IDX_SWID_LO)}; // RL12
  end

  // Write channel: address and data taken in either order
  logic aw_fire, w_fire, wr_do;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign wr_do         = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      wbyte_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end else if (wr_do) begin
        aw_have_q <= 1'b0;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_do) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en, go_req, bad_mode, empty_job, go;
  assign wr_en     = wr_do && wstrb0_q;
  assign go_req    = wr_en && (aw_idx_q == IDX_CTRL) && wbyte_q[CTRL_GO_BIT] && state_q == ST_IDLE;
  assign bad_mode  = ^wbyte_q[CTRL_MODE_LSB +: 2]; // RL14
  assign empty_job = lin_cfg_q ? (cnt_f == '0) : (wid_f == '0 || hgt_f == '0);
  assign go        = go_req && !bad_mode && !empty_job;

  // Parameter bytes; reserved slots never stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) win_q[i] <= BYTE_RST;
    end else if (wr_en && in_win(aw_idx_q) && !is_rsvd(aw_idx_q)) begin // RL13
      win_q[slot(aw_idx_q)] <= wbyte_q;
    end
  end

  // Mode select and SPI clock mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lin_cfg_q <= 1'b0;
      mode_q    <= 2'b00;
    end else if (wr_en) begin
      if (aw_idx_q == IDX_COLOR) lin_cfg_q <= wbyte_q[COLOR_LIN_BIT]; // RL3
      if (aw_idx_q == IDX_CTRL && state_q == ST_IDLE) mode_q <= wbyte_q[CTRL_MODE_LSB +: 2];
    end
  end
  assign spi_mode = mode_q;

  // Sticky done and error; a set beats a write-one clear
  logic fin;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      if (fin || (go_req && !bad_mode && empty_job)) done_q <= 1'b1;
      else if (wr_en && aw_idx_q == IDX_STAT && wbyte_q[STAT_DONE_BIT]) done_q <= 1'b0;
      if (go_req && bad_mode) err_q <= 1'b1; // RL14
      else if (wr_en && aw_idx_q == IDX_STAT && wbyte_q[STAT_ERR_BIT]) err_q <= 1'b0;
    end
  end

  // Read channel: answer one cycle after the address is taken
  logic [7:0] ar_idx, rd_byte;
  assign ar_idx        = s_axi_araddr[9:2];
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rd_byte = 8'h00;
    if (in_win(ar_idx) && !is_rsvd(ar_idx)) rd_byte = wb(ar_idx); // RL13
    else if (ar_idx == IDX_COLOR) rd_byte[COLOR_LIN_BIT] = lin_cfg_q;
    else if (ar_idx == IDX_CTRL) rd_byte[CTRL_MODE_LSB +: 2] = mode_q;
    else if (ar_idx == IDX_STAT) begin
      rd_byte[STAT_BUSY_BIT] = busy;
      rd_byte[STAT_DONE_BIT] = done_q;
      rd_byte[STAT_ERR_BIT]  = err_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Flash byte buffer with back-pressure to the SPI master
  sfdma_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (fl_data),
    .in_valid  (fl_data_valid),
    .in_ready  (fl_data_ready),
    .out_data  (ff_data),
    .out_valid (ff_valid),
    .out_ready (ff_pop)
  );

  logic last_px, last_row;
  assign mem_valid = (state_q == ST_XFER) && ff_valid;
  assign ff_pop    = (state_q == ST_XFER) && mem_ready;
  assign last_px   = mem_valid && mem_ready && (left_q == 32'd1);
  assign last_row  = lin_q || (rows_left_q == 16'd1);
  assign fin       = last_px && last_row;
  assign busy      = (state_q != ST_IDLE);

  // Engine sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (go) state_q <= ST_REQ;
        ST_REQ:  if (fl_req_ready) state_q <= ST_XFER;
        ST_XFER: if (last_px) state_q <= last_row ? ST_IDLE : ST_REQ; // RL15
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Job parameters latched at start, row stepping
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lin_q       <= 1'b0;
      row_addr_q  <= 32'h0000_0000;
      len_q       <= 32'h0000_0000;
      rows_left_q <= 16'h0000;
      swid_q      <= 13'h0000;
      dx_q        <= 13'h0000;
    end else if (go) begin
      lin_q       <= lin_cfg_q; // RL3
      row_addr_q  <= src_f; // RL2
      len_q       <= lin_cfg_q ? cnt_f : {16'h0000, wid_f}; // RL8 RL9 RL11
      rows_left_q <= hgt_f; // RL10
      swid_q      <= swid_f;
      dx_q        <= dx_f;
    end else if (last_px && !last_row) begin
      row_addr_q  <= row_addr_q + {19'h0, swid_q}; // RL15
      rows_left_q <= rows_left_q - 16'd1;
    end
  end

  // Destination position and per-row count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 32'h0000_0000;
      addr_q <= 32'h0000_0000;
      x_q    <= 13'h0000;
      y_q    <= 13'h0000;
    end else if (go) begin
      left_q <= lin_cfg_q ? cnt_f : {16'h0000, wid_f};
      addr_q <= lin_dst_f; // RL5 RL7
      x_q    <= dx_f; // RL4
      y_q    <= dy_f; // RL6
    end else if (mem_valid && mem_ready) begin
      if (last_px) begin
        left_q <= len_q;
        x_q    <= dx_q;
        y_q    <= y_q + 13'd1; // RL15
      end else begin
        left_q <= left_q - 32'd1;
        x_q    <= x_q + 13'd1;
      end
      addr_q <= addr_q + 32'd1; // RL16
    end
  end

  assign fl_req_valid = (state_q == ST_REQ);
  assign fl_req       = '{addr: row_addr_q, len: len_q}; // RL2
  assign mem_wr       = '{linear: lin_q, addr: addr_q, x: x_q, y: y_q, data: ff_data};

  sequence row_done_s;
    mem_valid && mem_ready && !lin_q && left_q == 32'd1 && rows_left_q > 16'd1;
  endsequence

  src_latch_a: assert property (go |=> fl_req.addr == $past(src_f) && busy) // RL1
    else $error("source address not latched");
  lin_sel_a: assert property (go |=> lin_q == $past(lin_cfg_q)) // RL3
    else $error("mode not taken from config bit");
  blk_xy_a: assert property (go && !lin_cfg_q |=> x_q == $past(dx_f) && y_q == $past(dy_f)) // RL4
    else $error("block corner wrong");
  lin_dst_a: assert property (go && lin_cfg_q |=> addr_q[1:0] == 2'b00 // RL5 RL7
      && addr_q == $past(lin_dst_f))
    else $error("linear destination wrong");
  lin_count_a: assert property (go && lin_cfg_q |=> fl_req.len == $past(cnt_f)) // RL11
    else $error("linear count wrong");
  blk_size_a: assert property (go && !lin_cfg_q |=> len_q == {16'h0, $past(wid_f)} // RL8 RL10
      && rows_left_q == $past(hgt_f))
    else $error("block size wrong");
  rsvd_zero_a: assert property (s_axi_arvalid && s_axi_arready && is_rsvd(ar_idx) // RL13
      |=> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("reserved byte not zero");
  spi_mode_a: assert property (go_req && bad_mode |=> state_q == ST_IDLE && err_q) // RL14
    else $error("start taken in bad SPI mode");
  row_step_a: assert property (row_done_s |=> state_q == ST_REQ // RL15
      && row_addr_q == $past(row_addr_q) + {19'h0, swid_q} && x_q == dx_q)
    else $error("row step wrong");
  lin_inc_a: assert property (mem_valid && mem_ready && lin_q // RL16
      |=> addr_q == $past(addr_q) + 32'd1)
    else $error("linear address not consecutive");
  fl_hold_a: assert property (fl_req_valid && !fl_req_ready // RL2
      |=> fl_req_valid && $stable(fl_req))
    else $error("flash request moved before taken");
  job_end_a: assert property (fin |=> state_q == ST_IDLE && done_q) // RL15 RL16
    else $error("job did not end on last beat");
  swid_latch_a: assert property (go |=> swid_q == $past(swid_f)) // RL12
    else $error("picture width not latched");
  spi_hold_a: assert property (busy |=> $stable(spi_mode)) // RL14
    else $error("SPI mode changed during a job");
endmodule // sfdma_top

// ### design/sfdma_pkg.sv
// Package: register map, field layout and carrier types of the flash image DMA setup
package sfdma_pkg;
  localparam logic [7:0] IDX_SRC0      = 8'hBC;
  localparam logic [7:0] IDX_SRC1      = 8'hBD;
  localparam logic [7:0] IDX_SRC2      = 8'hBE;
  localparam logic [7:0] IDX_SRC3      = 8'hBF;
  localparam logic [7:0] IDX_DX_LO     = 8'hC0;
  localparam logic [7:0] IDX_DX_HI     = 8'hC1;
  localparam logic [7:0] IDX_DY_LO     = 8'hC2;
  localparam logic [7:0] IDX_DY_HI     = 8'hC3;
  localparam logic [7:0] IDX_RSV0      = 8'hC4;
  localparam logic [7:0] IDX_RSV1      = 8'hC5;
  localparam logic [7:0] IDX_WID_LO    = 8'hC6;
  localparam logic [7:0] IDX_WID_HI    = 8'hC7;
  localparam logic [7:0] IDX_HGT_LO    = 8'hC8;
  localparam logic [7:0] IDX_HGT_HI    = 8'hC9;
  localparam logic [7:0] IDX_SWID_LO   = 8'hCA;
  localparam logic [7:0] IDX_SWID_HI   = 8'hCB;
  localparam logic [7:0] IDX_COLOR     = 8'h5E;
  localparam logic [7:0] IDX_CTRL      = 8'hF8;
  localparam logic [7:0] IDX_STAT      = 8'hF9;
  localparam int         COLOR_LIN_BIT = 2;
  localparam int         CTRL_GO_BIT   = 0;
  localparam int         CTRL_MODE_LSB = 1;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_DONE_BIT = 1;
  localparam int         STAT_ERR_BIT  = 2;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam int         COORD_W       = 13;
  localparam int         FIFO_DEPTH    = 16;
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_REQ = 2'b01, ST_XFER = 2'b10} sfdma_state_t;

  // Flash read run: start byte address and number of bytes
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] len;
  } sfdma_req_t;

  // One display-memory write: linear address or canvas X/Y
  typedef struct packed {
    logic               linear;
    logic [31:0]        addr;
    logic [COORD_W-1:0] x;
    logic [COORD_W-1:0] y;
    logic [7:0]         data;
  } sfdma_wr_t;
endpackage

// ### design/sfdma_fifo.sv
// Synchronous valid/ready FIFO in flip-flops
`timescale 1ns/10ps
module sfdma_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, rd_q;
  logic [AW:0]      cnt_q;
  logic             push, pop;

  // Honest full and empty from the fill count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sfdma_fifo

// ### tb/sfdma_flash_model.sv
// Behavioural serial flash behind the engine's read port
`timescale 1ns/10ps
module sfdma_flash_model
  import sfdma_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire sfdma_req_t fl_req,
  input  wire logic       fl_req_valid,
  output logic            fl_req_ready,
  output logic [7:0]      fl_data,
  output logic            fl_data_valid,
  input  wire logic       fl_data_ready
);
  int          sd = 4211;
  logic [31:0] a, n;
  logic        tk;

  // Image byte stored at a flash address
  function automatic logic [7:0] img(input logic [31:0] p);
    return p[7:0] ^ p[15:8] ^ p[31:24] ^ 8'h5A;
  endfunction

  // Take a run after a random delay, then stream it with random stalls
  initial begin
    fl_req_ready  = 1'b0;
    fl_data_valid = 1'b0;
    fl_data       = 8'h00;
    forever begin
      @(negedge clk);
      if (rst_b && fl_req_valid) begin
        repeat ($random(sd) & 3) @(posedge clk);
        @(posedge clk);
        fl_req_ready <= 1'b1;
        @(negedge clk);
        a = fl_req.addr;
        n = fl_req.len;
        @(posedge clk);
        fl_req_ready <= 1'b0;
        for (int i = 0; i < n; i++) begin
          if (($random(sd) & 3) == 0) begin
            fl_data_valid <= 1'b0;
            fl_data       <= ~fl_data;
            @(posedge clk);
          end
          fl_data_valid <= 1'b1;
          fl_data       <= img(a + i);
          do begin
            @(negedge clk);
            tk = fl_data_ready;
            @(posedge clk);
          end while (!tk);
        end
        fl_data_valid <= 1'b0;
        fl_data       <= ~fl_data;
      end
    end
  end
endmodule // sfdma_flash_model

// ### tb/test_serial_flash_image_dma_setup.sv
// Bench for the flash image DMA: registers, flash runs, memory writes
`timescale 1ns/10ps
module test_serial_flash_image_dma_setup
  import sfdma_pkg::*;
;
  logic        clk = 1'b0, rst_b = 1'b0, hold = 1'b0, mem_ready = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, src, cnt, base;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, spi_mode, r, m;
  logic        fl_req_valid, fl_req_ready, fl_data_valid, fl_data_ready, mem_valid, busy;
  logic [7:0]  fl_data, k, v, rg [16];
  logic [15:0] w, h;
  logic [12:0] sw, dx, dy;
  sfdma_req_t  fl_req, rq, exp_r [$];
  sfdma_wr_t   mem_wr, ew, mw, exp_w [$];
  int          seed = 7929, num_errors = 0, checked = 0, nacc = 0, n;

  sfdma_top uut (
    .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fl_req, .fl_req_valid, .fl_req_ready, .fl_data, .fl_data_valid, .fl_data_ready, .mem_wr,
    .mem_valid, .mem_ready, .spi_mode, .busy
  );
  sfdma_flash_model flash (
    .clk, .rst_b, .fl_req, .fl_req_valid, .fl_req_ready, .fl_data, .fl_data_valid,
    .fl_data_ready
  );

  // Free-running 10 MHz clock
  initial forever #50 clk = ~clk;

  // Hang guard far beyond the longest sequence
  initial begin
    #3000000;
    num_errors++;
    complete_run;
  end

  // Memory side stalls at random, or fully while the buffer fills
  always @(posedge clk) mem_ready <= !hold && (($random(seed) & 3) != 0);

  // Expected image byte at a flash address
  function automatic logic [7:0] img(input logic [31:0] p);
    return p[7:0] ^ p[15:8] ^ p[31:24] ^ 8'h5A;
  endfunction

  task automatic chk(input logic [71:0] g, input logic [71:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Write one register byte; offered address and data drop once taken
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, output logic [1:0] rr);
    logic ta, tw, tb;
    s_axi_awaddr  <= {2'b00, ix, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
  endtask

  // Read one register and compare word and response
  task automatic rc(input logic [7:0] ix, input logic [7:0] e, input logic [1:0] er);
    logic ta, tv;
    logic [33:0] g;
    s_axi_araddr  <= {2'b00, ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_arready;
      tv = s_axi_rvalid;
      g  = {s_axi_rresp, s_axi_rdata};
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tv);
    chk(g, {er, 24'h0, e});
  endtask

  task automatic prog;
    for (int q = 0; q < 16; q++) wr(8'hBC + 8'(q), rg[q], r);
  endtask

  // Wait, bounded, until the engine is idle and all traffic seen
  task automatic idle;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((busy || exp_w.size() > 0 || exp_r.size() > 0) && n < 4000);
    @(posedge clk);
    chk(n >= 4000, 0);
  endtask

  // Check every flash run and memory write against the expected queues
  always @(negedge clk) begin
    if (rst_b && fl_data_valid && fl_data_ready) nacc++;
    if (rst_b && fl_req_valid && fl_req_ready) begin
      if (exp_r.size() == 0) chk(1, 0);
      else chk(fl_req, exp_r.pop_front());
    end
    if (rst_b && mem_valid && mem_ready) begin
      if (exp_w.size() == 0) chk(1, 0);
      else begin
        mw = exp_w.pop_front();
        if (mw.linear) chk({mem_wr.linear, mem_wr.addr, mem_wr.data},
                           {mw.linear, mw.addr, mw.data});
        else chk({mem_wr.linear, mem_wr.x, mem_wr.y, mem_wr.data},
                 {mw.linear, mw.x, mw.y, mw.data});
      end
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({busy, fl_req_valid, mem_valid, spi_mode}, 0);
    for (k = IDX_SRC0; k <= IDX_SWID_HI; k++) rc(k, 8'h00, RESP_OKAY);
    rc(IDX_COLOR, 8'h00, RESP_OKAY);
    for (k = IDX_SRC0; k <= IDX_SWID_HI; k++) begin
      v = 8'($random(seed));
      wr(k, v, r);
      rc(k, (k == IDX_RSV0 || k == IDX_RSV1) ? 8'h00 : v, RESP_OKAY);
    end
    wr(IDX_COLOR, 8'hFF, r);
    rc(IDX_COLOR, 8'h04, RESP_OKAY);
    wr(8'h10, 8'h55, r);
    chk(r, RESP_SLVERR);
    rc(8'h10, 8'h00, RESP_SLVERR);
    wr(IDX_SRC0, 8'h3C, r);
    s_axi_wstrb <= 4'h0;
    wr(IDX_SRC0, 8'hC3, r);
    s_axi_wstrb <= 4'hF;
    rc(IDX_SRC0, 8'h3C, RESP_OKAY);
    // Clock modes 1 and 2 refuse to start
    for (m = 2'd1; m <= 2'd2; m++) begin
      wr(IDX_CTRL, {5'b0, m, 1'b1}, r);
      idle;
      rc(IDX_STAT, 8'h04, RESP_OKAY);
      wr(IDX_STAT, 8'h04, r);
    end
    rc(IDX_STAT, 8'h00, RESP_OKAY);
    // Block copy with junk in unused high bits
    src = $random(seed);
    sw  = 13'd5 + 13'($random(seed) & 7);
    dx  = 13'($random(seed)) & 13'h0FFF;
    dy  = 13'($random(seed)) & 13'h0FFF;
    w   = 16'd1 + 16'($random(seed) & 3);
    h   = 16'd2 + 16'($random(seed) & 1);
    rg  = '{src[7:0], src[15:8], src[23:16], src[31:24], dx[7:0], {3'h5, dx[12:8]},
            dy[7:0], {3'h6, dy[12:8]}, 8'h00, 8'h00, w[7:0], w[15:8], h[7:0], h[15:8],
            sw[7:0], {3'h7, sw[12:8]}};
    for (int i = 0; i < h; i++) begin
      rq.addr = src + i * sw;
      rq.len  = 32'(w);
      exp_r.push_back(rq);
      for (int j = 0; j < w; j++) begin
        ew      = '0;
        ew.x    = dx + 13'(j);
        ew.y    = dy + 13'(i);
        ew.data = img(rq.addr + j);
        exp_w.push_back(ew);
      end
    end
    wr(IDX_COLOR, 8'h00, r);
    prog;
    wr(IDX_CTRL, 8'h01, r);
    idle;
    chk(spi_mode, 2'd0);
    // Linear copy longer than the buffer, memory side held off first
    src  = $random(seed);
    base = $random(seed) & 32'hFFFFFFFC;
    cnt  = 32'd24;
    rg   = '{src[7:0], src[15:8], src[23:16], src[31:24], base[7:0] | 8'h03, base[15:8],
             base[23:16], base[31:24], 8'h00, 8'h00, cnt[7:0], cnt[15:8], cnt[23:16],
             cnt[31:24], 8'h00, 8'h00};
    rq.addr = src;
    rq.len  = cnt;
    exp_r.push_back(rq);
    for (int j = 0; j < cnt; j++) begin
      ew        = '0;
      ew.linear = 1'b1;
      ew.addr   = base + j;
      ew.data   = img(src + j);
      exp_w.push_back(ew);
    end
    wr(IDX_COLOR, 8'h04, r);
    prog;
    hold <= 1'b1;
    nacc = 0;
    wr(IDX_CTRL, 8'h07, r);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (fl_data_ready && n < 400);
    chk(nacc, FIFO_DEPTH);
    @(posedge clk);
    hold <= 1'b0;
    idle;
    chk(spi_mode, 2'd3);
    rc(IDX_STAT, 8'h02, RESP_OKAY);
    complete_run;
  end
endmodule // test_serial_flash_image_dma_setup
